// ==== madc_pkg.sv ====
// Summary of operation
// - eight byte-wide registers reachable over two-wire bus
// - control, auxiliary, test registers read and write
// - status, data low, identifier registers read only
// - answer only when upper address bits match strap
// - low three address bits select the register
// - select codes map to the eight registers
// - full address is strap bits then select
// - address and data shifted msb first
// - 24-bit fused identifier readable as three bytes
// - master picks channel, starts, reads 12-bit result
// - channel zero measures the 20uA source node
// - start bit clears itself when conversion ends
// - idle flag in status; start only when idle
// - control bit 6 resets all read/write registers
`default_nettype none
package madc_pkg;
    localparam logic [2:0] MADC_SEL_CTRL  = 3'h0;
    localparam logic [2:0] MADC_SEL_STAT  = 3'h1;
    localparam logic [2:0] MADC_SEL_AUX   = 3'h2;
    localparam logic [2:0] MADC_SEL_LOW   = 3'h3;
    localparam logic [2:0] MADC_SEL_TEST  = 3'h4;
    localparam logic [2:0] MADC_SEL_IDL   = 3'h5;
    localparam logic [2:0] MADC_SEL_IDM   = 3'h6;
    localparam logic [2:0] MADC_SEL_IDH   = 3'h7;
    localparam int         MADC_BIT_START = 7;
    localparam int         MADC_BIT_SWRST = 6;
    localparam int         MADC_BIT_IDLE  = 7;
    localparam logic [7:0] MADC_CTRL_RST  = 8'h00;
    localparam logic [7:0] MADC_AUX_RST   = 8'h00;
    localparam logic [7:0] MADC_TEST_RST  = 8'h10;
    // channel wired to the 20uA source
    localparam logic [2:0] MADC_CH_I20    = 3'h0;
    localparam real        MADC_CLK_MHZ   = 40.0;
    localparam real        MADC_CONV_US   = 250.0;
    localparam int         MADC_CONV_CYC  = int'(MADC_CONV_US * MADC_CLK_MHZ);

    typedef struct packed {
        logic       start;
        logic [2:0] chan;
    } madc_conv_req_t;

    typedef struct packed {
        logic        done;
        logic [11:0] result;
    } madc_conv_rsp_t;
endpackage
`default_nettype wire

// ==== madc_i2c_regs.sv ====
`default_nettype none
module madc_i2c_regs
    import madc_pkg::*;
#(
    parameter int          CONV_CYCLES = MADC_CONV_CYC,
    parameter logic [23:0] CHIP_ID     = 24'h5a5a5a // arbitrary value
) (
    input  wire logic                    CLK,       // system clock
    input  wire logic                    RST_B,     // async reset, low
    input  wire logic                    SCL,       // bus clock pin
    input  wire logic                    SDA_IN,    // bus data level
    output var  logic                    SDA_OUT,   // data drive value
    output var  logic                    SDA_OE,    // high while pulling low
    input  wire logic [3:0]              CHIP_ADDR, // strapped chip address
    output var  madc_pkg::madc_conv_req_t CONV_REQ, // channel and start to core
    input  wire madc_pkg::madc_conv_rsp_t CONV_RSP, // converter result
    output var  logic                    I20_SEL,   // source node on mux
    output var  logic [7:0]              AUX_OUT,   // auxiliary settings
    output var  logic [7:0]              TEST_OUT   // test settings
);
    import madc_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_q, sda_q;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], SCL};
            sda_s_q <= {sda_s_q[0], SDA_IN};
            scl_q   <= scl_s_q[1];
            sda_q   <= sda_s_q[1];
        end
    end
    wire scl_rise = scl_s_q[1] & ~scl_q;
    wire scl_fall = ~scl_s_q[1] & scl_q;
    wire start_c  = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    wire stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

    // strap pins, two flops before the address compare
    logic [3:0] strap_s_q, strap_q;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_s_q <= 4'h0;
            strap_q   <= 4'h0;
        end else begin
            strap_s_q <= CHIP_ADDR;
            strap_q   <= strap_s_q;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_q, aux_q, test_q;
    logic [11:0] result_q;
    logic        busy_q;
    logic [31:0] conv_cnt_q;
    logic        wr_stb;
    logic [2:0]  sel_q;
    logic [7:0]  sh_q;

    // only three selects take a write, the rest ignore it
    wire ctrl_we = wr_stb && sel_q == MADC_SEL_CTRL;
    wire aux_we  = wr_stb && sel_q == MADC_SEL_AUX;
    wire test_we = wr_stb && sel_q == MADC_SEL_TEST;
    wire sw_rst  = ctrl_we && sh_q[MADC_BIT_SWRST];

    function automatic logic [7:0] rd_mux(input logic [2:0] s);
        case (s)
            MADC_SEL_CTRL: rd_mux = ctrl_q;
            MADC_SEL_STAT: rd_mux = {~busy_q, 3'h0, result_q[11:8]};
            MADC_SEL_AUX:  rd_mux = aux_q;
            MADC_SEL_LOW:  rd_mux = result_q[7:0];
            MADC_SEL_TEST: rd_mux = test_q;
            MADC_SEL_IDL:  rd_mux = CHIP_ID[7:0];
            MADC_SEL_IDM:  rd_mux = CHIP_ID[15:8];
            MADC_SEL_IDH:  rd_mux = CHIP_ID[23:16];
            default:       rd_mux = 8'h00;
        endcase
    endfunction

    wire [7:0] rd_byte = rd_mux(sel_q);

    wire conv_done = busy_q && (conv_cnt_q == 32'(CONV_CYCLES - 1));
    wire go        = ctrl_q[MADC_BIT_START] && !busy_q;
    // a write landing in the same cycle as end of conversion wins over the clear
    wire start_keep = busy_q && !conv_done;
    wire [7:0] ctrl_wdat = {sh_q[MADC_BIT_START] | start_keep, sh_q[6:0]};

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= MADC_CTRL_RST;
            aux_q  <= MADC_AUX_RST;
            test_q <= MADC_TEST_RST;
        end else if (sw_rst) begin
            ctrl_q <= MADC_CTRL_RST;
            aux_q  <= MADC_AUX_RST;
            test_q <= MADC_TEST_RST;
        end else begin
            if (ctrl_we) begin
                ctrl_q <= ctrl_wdat;
            end else if (conv_done) begin
                ctrl_q[MADC_BIT_START] <= 1'b0;
            end
            if (aux_we) begin
                aux_q <= sh_q;
            end
            if (test_we) begin
                test_q <= sh_q;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_q     <= 1'b0;
            conv_cnt_q <= 32'h0;
            result_q   <= 12'h000;
        end else if (go) begin
            busy_q     <= 1'b1;
            conv_cnt_q <= 32'h0;
        end else if (conv_done) begin
            busy_q   <= 1'b0;
            result_q <= CONV_RSP.result;
        end else if (busy_q) begin
            conv_cnt_q <= conv_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    typedef enum {MADC_IDLE, MADC_ADDR, MADC_AACK, MADC_WDAT, MADC_WACK,
                  MADC_RDAT, MADC_RACK} madc_st_t;
    madc_st_t   st_q;
    logic [3:0] cnt_q;
    logic       rw_q, drv_q;
    logic       wr_q;

    assign wr_stb = wr_q;
    wire addr_hit = sh_q[7:4] == strap_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q  <= MADC_IDLE;
            cnt_q <= 4'h0;
            sh_q  <= 8'h00;
            sel_q <= 3'h0;
            rw_q  <= 1'b0;
            drv_q <= 1'b0;
            wr_q  <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            if (start_c) begin
                st_q  <= MADC_ADDR;
                cnt_q <= 4'h0;
                drv_q <= 1'b0;
            end else if (stop_c) begin
                st_q  <= MADC_IDLE;
                drv_q <= 1'b0;
            end else begin
                case (st_q)
                    MADC_ADDR: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], sda_q};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == 4'h8) begin
                            if (addr_hit) begin
                                sel_q <= sh_q[3:1];
                                rw_q  <= sh_q[0];
                                drv_q <= 1'b1;
                                st_q  <= MADC_AACK;
                            end else begin
                                st_q <= MADC_IDLE;
                            end
                        end
                    end
                    MADC_AACK, MADC_WACK: begin
                        if (scl_fall) begin
                            cnt_q <= 4'h0;
                            if (rw_q) begin
                                sh_q  <= rd_byte;
                                drv_q <= ~rd_byte[7];
                                st_q  <= MADC_RDAT;
                            end else begin
                                drv_q <= 1'b0;
                                st_q  <= MADC_WDAT;
                            end
                        end
                    end
                    MADC_WDAT: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], sda_q};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == 4'h8) begin
                            wr_q  <= 1'b1;
                            drv_q <= 1'b1;
                            st_q  <= MADC_WACK;
                        end
                    end
                    MADC_RDAT: begin
                        if (scl_fall) begin
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q == 4'h7) begin
                                drv_q <= 1'b0;
                                st_q  <= MADC_RACK;
                            end else begin
                                sh_q  <= {sh_q[6:0], 1'b0};
                                drv_q <= ~sh_q[6];
                            end
                        end
                    end
                    MADC_RACK: begin
                        if (scl_rise) begin
                            st_q <= sda_q ? MADC_IDLE : MADC_RACK;
                        end else if (scl_fall) begin
                            cnt_q <= 4'h0;
                            sh_q  <= rd_byte;
                            drv_q <= ~rd_byte[7];
                            st_q  <= MADC_RDAT;
                        end
                    end
                    default: drv_q <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SDA_OUT  <= 1'b0;
            CONV_REQ <= '0;
            I20_SEL  <= 1'b0;
            AUX_OUT  <= MADC_AUX_RST;
            TEST_OUT <= MADC_TEST_RST;
        end else begin
            SDA_OUT        <= 1'b0;
            CONV_REQ.start <= go;
            CONV_REQ.chan  <= ctrl_q[2:0];
            I20_SEL        <= ctrl_q[2:0] == MADC_CH_I20;
            AUX_OUT        <= aux_q;
            TEST_OUT       <= test_q;
        end
    end

    // enable straight from the drive flop, so it settles while the clock is low
    assign SDA_OE = drv_q;
endmodule
`default_nettype wire

// ==== madc_i2c_master.sv ====
`default_nettype none
module madc_i2c_master (
    input  wire logic CLK,   // bench clock
    input  wire logic SDA,   // resolved wire
    output var  logic SCL,   // link clock
    output var  logic SDA_LO // pulls data low
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        SCL = 1'b1;
        SDA_LO = 1'b0;
    end
    task automatic frame_start();
        @(posedge CLK) #2;
        SDA_LO = 1'b1;
        #50 SCL = 1'b0;
        #50;
    endtask
    task automatic frame_stop();
        #50 SDA_LO = 1'b1;
        #50 SCL = 1'b1;
        #50 SDA_LO = 1'b0;
        #100;
    endtask
    // eight bits then acknowledge
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #50 SDA_LO = !tx[i];
            #50 SCL = 1'b1;
            #50 rx[i] = SDA;
            #50 SCL = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== madc_i2c_regs_props.sv ====
`default_nettype none
module madc_i2c_regs_props
    import madc_pkg::*;
#(
    parameter int CONV_CYCLES = MADC_CONV_CYC
) (
    input wire logic           CLK,       // clock
    input wire logic           RST_B,     // reset
    input wire logic           SCL,       // link clock
    input wire logic           SDA_IN,    // data wire
    input wire logic           SDA_OUT,   // drive value
    input wire logic           SDA_OE,    // drive enable
    input wire logic [3:0]     CHIP_ADDR, // strap
    input wire madc_conv_req_t CONV_REQ,  // to core
    input wire madc_conv_rsp_t CONV_RSP,  // from core
    input wire logic           I20_SEL,   // source select
    input wire logic [7:0]     AUX_OUT,   // aux copy
    input wire logic [7:0]     TEST_OUT   // test copy
);
    int cnt_q;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_q <= 0;
        end else if (CONV_REQ.start) begin
            cnt_q <= CONV_CYCLES;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_ch0;
        (CONV_REQ.chan == MADC_CH_I20) [*2];
    endsequence
    sequence s_chx;
        (CONV_REQ.chan != MADC_CH_I20) [*2];
    endsequence
    a_i20_on: assert property (s_ch0 |-> I20_SEL)
        else $error("source select low");
    a_i20_off: assert property (s_chx |-> !I20_SEL)
        else $error("source select high");
    a_start_pulse: assert property (CONV_REQ.start |=> !CONV_REQ.start)
        else $error("start not a pulse");
    a_start_idle: assert property (CONV_REQ.start |-> cnt_q <= 2)
        else $error("start while busy");
    a_oe_rise_low: assert property ($rose(SDA_OE) |-> !SCL)
        else $error("drive began with clock high");
    a_oe_fall_low: assert property ($fell(SDA_OE) |-> !SCL)
        else $error("drive ended with clock high");
    a_bit_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*6])
        else $error("bit not held");
    a_drive_low: assert property (SDA_OE |-> !SDA_OUT)
        else $error("data driven high");
    a_reset_vals: assert property ($rose(RST_B) |->
        AUX_OUT == MADC_AUX_RST && TEST_OUT == MADC_TEST_RST)
        else $error("bad reset value");
endmodule
bind madc_i2c_regs madc_i2c_regs_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (
    .CLK(CLK), .RST_B(RST_B), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .CHIP_ADDR(CHIP_ADDR), .CONV_REQ(CONV_REQ), .CONV_RSP(CONV_RSP),
    .I20_SEL(I20_SEL), .AUX_OUT(AUX_OUT), .TEST_OUT(TEST_OUT));
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import madc_pkg::*;
    localparam int          CONV = 400;
    localparam logic [23:0] ID   = 24'h3c96e1; // arbitrary value
    logic clk, rst_b, scl, sda, sda_lo, sda_out, sda_oe, i20_sel, a;
    logic [3:0] chip_addr;
    logic [7:0] aux_out, test_out, v;
    logic [2:0] ch;
    logic [11:0] res;
    logic [8:0] rx;
    madc_conv_req_t conv_req;
    madc_conv_rsp_t conv_rsp;
    int n_mismatch = 0, tests_run = 0, seed = 52;
    int mdl [8];
    assign sda = !sda_lo && !(sda_oe && !sda_out);
    madc_i2c_regs #(.CONV_CYCLES(CONV), .CHIP_ID(ID)) dut_u (
        .CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .CHIP_ADDR(chip_addr), .CONV_REQ(conv_req),
        .CONV_RSP(conv_rsp), .I20_SEL(i20_sel), .AUX_OUT(aux_out), .TEST_OUT(test_out));
    madc_i2c_master m_u (.CLK(clk), .SDA(sda), .SCL(scl), .SDA_LO(sda_lo));
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [3:0] ca, input logic [2:0] sel, input logic rd,
                       input logic [7:0] wd, output logic ack, output logic [7:0] q);
        m_u.frame_start();
        m_u.xfer({ca, sel, rd, 1'b1}, rx);
        ack = !rx[0];
        if (ack) begin
            m_u.xfer(rd ? 9'h1ff : {wd, 1'b1}, rx);
            q = rx[8:1];
        end
        m_u.frame_stop();
    endtask
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        acc(chip_addr, sel, 1'b0, d, a, v);
        chk(a, 1'b1);
    endtask
    task automatic rdchk(input logic [2:0] sel);
        acc(chip_addr, sel, 1'b1, 8'h00, a, v);
        chk(v, mdl[sel][7:0]);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        results();
    end
    initial begin
        rst_b = 1'b0;
        chip_addr = 4'($random(seed));
        conv_rsp = '0;
        repeat (20) @(posedge clk);
        #2 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        mdl = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h10, ID[7:0], ID[15:8], ID[23:16]};
        for (int s = 0; s < 8; s++) rdchk(3'(s));
        chk(i20_sel, 1'b1);
        $display("test reset values done");
        for (int s = 1; s < 8; s++) begin
            v = 8'($random(seed));
            if (s == 2 || s == 4) mdl[s] = v;
            wr(3'(s), v);
            rdchk(3'(s));
        end
        chk(aux_out, mdl[2][7:0]);
        chk(test_out, mdl[4][7:0]);
        $display("test register access done");
        for (int k = 0; k < 4; k++) begin
            acc(chip_addr ^ 4'(1 << k), 3'h2, 1'b1, 8'h00, a, v);
            chk(a, 1'b0);
        end
        $display("test chip address done");
        for (int k = 0; k < 3; k++) begin
            ch = (k == 0) ? 3'h0 : 3'($random(seed));
            res = 12'($random(seed));
            conv_rsp = {1'b0, res};
            wr(3'h0, {5'b10000, ch});
            mdl[0] = {5'b10000, ch};
            mdl[1][7] = 1'b0;
            rdchk(3'h1);
            repeat (CONV) @(posedge clk);
            mdl[0][7] = 1'b0;
            mdl[1] = {4'h8, res[11:8]};
            mdl[3] = res[7:0];
            for (int s = 0; s < 4; s++) rdchk(3'(s));
            chk(conv_req.chan, ch);
            chk(i20_sel, ch == MADC_CH_I20);
        end
        $display("test conversion done");
        wr(3'h2, 8'h5a);
        wr(3'h0, 8'h43);
        mdl[0] = 0;
        mdl[2] = 0;
        mdl[4] = 8'h10;
        for (int s = 0; s < 5; s += 2) rdchk(3'(s));
        chk(test_out, 8'h10);
        $display("test soft reset done");
        wr(3'h2, 8'h33);
        @(posedge clk);
        #2 rst_b = 1'b0;
        repeat (3) @(posedge clk);
        #2 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        mdl[1] = 8'h80;
        mdl[2] = 0;
        mdl[3] = 0;
        for (int s = 0; s < 5; s++) rdchk(3'(s));
        chk(aux_out, 8'h00);
        $display("test pin reset done");
        results();
    end
endmodule
`default_nettype wire
